// [eprom_boot_pkg.sv]
// shared constants, field layouts and carriers for the eprom bootload and
// programming control block
// assumes an ahb-lite master with 32-bit data and a cpu-side eprom port
package eprom_boot_pkg;

  // register byte offsets within the slave window
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] LAMP_OFFSET   = 8'h08;

  // nvm_burn_control field positions and reset value
  localparam int         HOLD_BIT   = 2;
  localparam int         BURN_BIT   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register field positions
  localparam int ST_BOOT_BIT   = 0;
  localparam int ST_FN_LSB     = 1;
  localparam int ST_HOLD_BIT   = 4;
  localparam int ST_BURN_BIT   = 5;
  localparam int ST_LATCH_BIT  = 6;
  localparam int ST_READ_BIT   = 7;

  // lamp register field positions
  localparam int LAMP_BURN_BIT  = 0;
  localparam int LAMP_CHECK_BIT = 1;

  // eprom geometry and the bootloader rom window
  localparam int          EPROM_ADDR_W   = 16;
  localparam int          EPROM_DATA_W   = 8;
  localparam logic [15:0] BOOT_ROM_FIRST = 16'h3F00;
  localparam logic [15:0] BOOT_ROM_LAST  = 16'h3FEF;

  // ahb-lite encodings used by the slave
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // bootloader function chosen by the three select pins
  typedef enum logic [2:0] {
    FN_NVM_BURN_CONTROL_VERIFY = 3'b000,
    FN_VERIFY_ONLY = 3'b001,
    FN_LOAD_EXEC   = 3'b010,
    FN_SECURE      = 3'b011,
    FN_NONE        = 3'b100
  } boot_fn_t;

  // ahb-lite request side as seen by the slave
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  // ahb-lite answer side
  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ahb_resp_t;

  // mode straps and function select pins
  typedef struct packed {
    logic irq_at_test_level;
    logic capture_input_pin;
    logic function_select_high;
    logic function_select_mid;
    logic function_select_low;
  } boot_pins_t;

  // cpu write towards an eprom location
  typedef struct packed {
    logic                    valid;
    logic [EPROM_ADDR_W-1:0] addr;
    logic [EPROM_DATA_W-1:0] data;
  } eprom_wr_t;

  // controls towards the eprom array
  typedef struct packed {
    logic                    read_en;
    logic                    nvm_burn_control_voltage;
    logic                    latch_valid;
    logic [EPROM_ADDR_W-1:0] latch_addr;
    logic [EPROM_DATA_W-1:0] latch_data;
  } eprom_ctl_t;

  // indicator pins, output enable low while driving
  typedef struct packed {
    logic burn_indicator_pin_o;
    logic burn_indicator_pin_oe_n;
    logic check_indicator_pin_o;
    logic check_indicator_pin_oe_n;
  } lamp_pins_t;

endpackage : eprom_boot_pkg

// [eprom_bootload_program_control.sv]
// eprom bootload mode entry, function select decode and programming control
// with an ahb-lite register slave
// assumes all pin inputs are synchronous to hclk and the cpu eprom write
// port presents one-cycle write strobes
`timescale 1ns/1ps
`default_nettype none

module eprom_bootload_program_control
  import eprom_boot_pkg::*;
(
  input  wire  logic                     hclk,
  input  wire  logic                     hresetn,
  input  wire  eprom_boot_pkg::ahb_req_t   bus_req,
  output var   eprom_boot_pkg::ahb_resp_t  bus_resp,
  input  wire  eprom_boot_pkg::boot_pins_t pins,
  input  wire  eprom_boot_pkg::eprom_wr_t  cpu_wr,
  input  wire  logic [15:0]              cpu_addr,
  output var   eprom_boot_pkg::eprom_ctl_t eprom_ctl,
  output var   eprom_boot_pkg::lamp_pins_t lamps,
  output var   logic                     boot_mode,
  output var   eprom_boot_pkg::boot_fn_t   boot_function,
  output var   logic                     boot_rom_select
);
  import eprom_boot_pkg::*;

  // every flip-flop of the block lives in this one record
  typedef struct packed {
    logic                    strap_taken;  // mode straps already caught
    logic                    boot_mode;    // bootloader mode active
    boot_fn_t                fn;           // decoded bootloader function
    logic                    hold;         // bus hold bit
    logic                    burn;         // burn voltage bit
    logic                    read_en;      // normal eprom reading allowed
    logic                    latch_valid;  // a write has been latched
    logic [EPROM_ADDR_W-1:0] latch_addr;   // latched eprom address
    logic [EPROM_DATA_W-1:0] latch_data;   // latched eprom data
    logic                    lamp_burn;    // burn lamp level
    logic                    lamp_check;   // check lamp level
    logic                    rom_sel;      // cpu inside bootloader rom
    logic                    dph_valid;    // ahb data phase pending
    logic                    dph_write;    // pending phase is a write
    logic [7:0]              dph_addr;     // pending phase byte offset
    logic                    hreadyout;    // ahb ready answer
    logic [31:0]             hrdata;       // ahb read data
  } block_state_t;

  block_state_t s_reg;   // registered state
  block_state_t s_next;  // next state

  // decode the three select pins; the high pin overrides the other two
  function automatic boot_fn_t decode_fn(input logic hi, input logic mid,
                                         input logic lo);
    boot_fn_t f;
    f = FN_NONE;
    if (hi)
      f = FN_SECURE;
    else if (!mid && !lo)
      f = FN_NVM_BURN_CONTROL_VERIFY;
    else if (!mid && lo)
      f = FN_VERIFY_ONLY;
    else if (mid && !lo)
      f = FN_LOAD_EXEC;
    return f;
  endfunction : decode_fn

  // true when a cpu address falls in the bootloader rom window
  function automatic logic in_boot_rom(input logic [15:0] a);
    return (a >= BOOT_ROM_FIRST) && (a <= BOOT_ROM_LAST);
  endfunction : in_boot_rom

  // assemble the status word from a state record
  function automatic logic [31:0] status_word(input block_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ST_BOOT_BIT]               = st.boot_mode;
    w[ST_FN_LSB +: 3]            = st.fn;
    w[ST_HOLD_BIT]               = st.hold;
    w[ST_BURN_BIT]               = st.burn;
    w[ST_LATCH_BIT]              = st.latch_valid;
    w[ST_READ_BIT]               = st.read_en;
    return w;
  endfunction : status_word

  // next-state logic for straps, registers, latch and bus slave
  always_comb
  begin
    logic [7:0] wr_byte;
    logic       addr_phase;
    s_next     = s_reg;
    wr_byte    = bus_req.hwdata[7:0];
    addr_phase = bus_req.hsel && (bus_req.htrans == HTRANS_NONSEQ) &&
                 bus_req.hready;

    // straps are caught once, on the first edge after reset release
    if (!s_reg.strap_taken)
    begin
      s_next.strap_taken = 1'b1;
      s_next.boot_mode   = pins.irq_at_test_level &&
                           pins.capture_input_pin;
    end

    // function select only means something in bootloader mode
    if (s_reg.boot_mode)
      s_next.fn = decode_fn(pins.function_select_high,
                            pins.function_select_mid,
                            pins.function_select_low);
    else
      s_next.fn = FN_NONE;

    // data phase of a write: hwdata is valid now
    if (s_reg.dph_valid && s_reg.dph_write)
    begin
      if (s_reg.dph_addr == CTRL_OFFSET)
      begin
        // bits other than hold and burn are dropped, so software that
        // writes them as zero and software that does not behave alike
        s_next.hold = wr_byte[HOLD_BIT];
        // burn needs hold both already set and kept set by this write
        s_next.burn = wr_byte[BURN_BIT] && wr_byte[HOLD_BIT] &&
                      s_reg.hold;
      end
      else if (s_reg.dph_addr == LAMP_OFFSET)
      begin
        // lamps belong to the bootloader; user mode writes are ignored
        if (s_reg.boot_mode)
        begin
          s_next.lamp_burn  = wr_byte[LAMP_BURN_BIT];
          s_next.lamp_check = wr_byte[LAMP_CHECK_BIT];
        end
      end
    end

    // address and data latch towards the array
    if (!s_next.hold)
    begin
      s_next.latch_valid = 1'b0;
    end
    else if (s_reg.hold && !s_reg.latch_valid && cpu_wr.valid)
    begin
      // only the first eprom write after hold is kept
      s_next.latch_valid = 1'b1;
      s_next.latch_addr  = cpu_wr.addr;
      s_next.latch_data  = cpu_wr.data;
    end
    s_next.read_en = !s_next.hold;

    // bootloader rom window select, one cycle behind cpu_addr
    s_next.rom_sel = in_boot_rom(cpu_addr);

    // ahb address phase capture
    s_next.dph_valid = addr_phase;
    s_next.dph_write = bus_req.hwrite;
    s_next.dph_addr  = bus_req.haddr[7:0];
    s_next.hreadyout = 1'b1;

    // read data is taken from next state so a read right behind a
    // write already sees the written value
    s_next.hrdata = 32'h0000_0000;
    if (addr_phase && !bus_req.hwrite)
    begin
      if (bus_req.haddr[7:0] == CTRL_OFFSET)
      begin
        s_next.hrdata[HOLD_BIT] = s_next.hold;
        s_next.hrdata[BURN_BIT] = s_next.burn;
      end
      else if (bus_req.haddr[7:0] == STATUS_OFFSET)
      begin
        s_next.hrdata = status_word(s_next);
      end
      else if (bus_req.haddr[7:0] == LAMP_OFFSET)
      begin
        s_next.hrdata[LAMP_BURN_BIT]  = s_next.lamp_burn;
        s_next.hrdata[LAMP_CHECK_BIT] = s_next.lamp_check;
      end
    end
  end

  // state register; reset gives user mode, volts off, bus idle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg             <= '0;
      s_reg.fn          <= FN_NONE;
      s_reg.hold        <= CTRL_RESET[HOLD_BIT];
      s_reg.burn        <= CTRL_RESET[BURN_BIT];
      s_reg.read_en     <= 1'b1;
      s_reg.hreadyout   <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs come straight from the state record; hresp is tied to okay
  assign bus_resp.hreadyout = s_reg.hreadyout;
  assign bus_resp.hresp     = HRESP_OKAY;
  assign bus_resp.hrdata    = s_reg.hrdata;

  // array controls; voltage follows the burn bit only
  assign eprom_ctl.read_en      = s_reg.read_en;
  assign eprom_ctl.nvm_burn_control_voltage = s_reg.burn;
  assign eprom_ctl.latch_valid  = s_reg.latch_valid;
  assign eprom_ctl.latch_addr   = s_reg.latch_addr;
  assign eprom_ctl.latch_data   = s_reg.latch_data;

  // lamp pins are released in user mode so the port stays ordinary
  assign lamps.burn_indicator_pin_o     = s_reg.lamp_burn;
  assign lamps.burn_indicator_pin_oe_n  = !s_reg.boot_mode;
  assign lamps.check_indicator_pin_o    = s_reg.lamp_check;
  assign lamps.check_indicator_pin_oe_n = !s_reg.boot_mode;

  assign boot_mode       = s_reg.boot_mode;
  assign boot_function   = s_reg.fn;
  assign boot_rom_select = s_reg.rom_sel;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // helper: a control write is in its data phase
  logic ctrl_wr_now;
  assign ctrl_wr_now = s_reg.dph_valid && s_reg.dph_write &&
                       (s_reg.dph_addr == CTRL_OFFSET);

  // helper: a lamp write is in its data phase in bootloader mode
  logic lamp_wr_now;
  assign lamp_wr_now = s_reg.dph_valid && s_reg.dph_write &&
                       s_reg.boot_mode && (s_reg.dph_addr == LAMP_OFFSET);

  // straps caught on the first edge decide the mode for good
  property p_strap_mode;
    !s_reg.strap_taken |=> boot_mode ==
      ($past(pins.irq_at_test_level) && $past(pins.capture_input_pin))
      ##1 $stable(boot_mode)[*3];
  endproperty
  a_strap_mode: assert property (p_strap_mode)
    else $error("mode not taken from straps at reset release");

  // rom select tracks the window one cycle later
  property p_rom_window;
    in_boot_rom(cpu_addr) |=> boot_rom_select;
  endproperty
  a_rom_window: assert property (p_rom_window)
    else $error("boot rom window not selected");

  // the high select pin forces secure one edge on
  property p_secure;
    boot_mode && pins.function_select_high |=> boot_function == FN_SECURE;
  endproperty
  a_secure: assert property (p_secure)
    else $error("secure function not chosen");

  // lamp pins are only driven in bootloader mode
  property p_lamp_release;
    !boot_mode |-> lamps.burn_indicator_pin_oe_n &&
                   lamps.check_indicator_pin_oe_n;
  endproperty
  a_lamp_release: assert property (p_lamp_release)
    else $error("lamp pins driven outside bootloader mode");

  // with hold set, the first eprom write is latched as presented
  property p_latch;
    s_reg.hold && !s_reg.latch_valid && cpu_wr.valid && !ctrl_wr_now
      |=> eprom_ctl.latch_valid &&
          eprom_ctl.latch_addr == $past(cpu_wr.addr) &&
          eprom_ctl.latch_data == $past(cpu_wr.data) && !eprom_ctl.read_en;
  endproperty
  a_latch: assert property (p_latch)
    else $error("eprom write not latched under hold");

  // writing hold clear restores reading and drops the latch
  property p_read_path;
    ctrl_wr_now && !bus_req.hwdata[HOLD_BIT]
      |=> eprom_ctl.read_en && !eprom_ctl.latch_valid;
  endproperty
  a_read_path: assert property (p_read_path)
    else $error("read path not restored after hold clear");

  // burn may only rise when hold was already set
  property p_burn_needs_hold;
    $rose(s_reg.burn) |-> $past(s_reg.hold, 1) && s_reg.hold;
  endproperty
  a_burn_needs_hold: assert property (p_burn_needs_hold)
    else $error("burn set without prior hold");

  // setting both from hold clear only sets hold
  property p_no_double_set;
    ctrl_wr_now && !s_reg.hold && bus_req.hwdata[HOLD_BIT] &&
      bus_req.hwdata[BURN_BIT] |=> s_reg.hold && !eprom_ctl.nvm_burn_control_voltage;
  endproperty
  a_no_double_set: assert property (p_no_double_set)
    else $error("hold and burn set by one write");

  // programming voltage never coexists with normal reading
  property p_voltage;
    eprom_ctl.nvm_burn_control_voltage |-> !eprom_ctl.read_en && s_reg.hold;
  endproperty
  a_voltage: assert property (p_voltage)
    else $error("voltage applied while reading enabled");

  // the slave never inserts wait states
  property p_zero_wait;
    bus_req.hsel && bus_req.htrans == HTRANS_NONSEQ && bus_req.hready
      |=> bus_resp.hreadyout && bus_resp.hresp == HRESP_OKAY;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("slave stalled or answered with error");

  // lamp levels follow a bootloader lamp write one edge later
  property p_lamp_write;
    lamp_wr_now |=>
      lamps.burn_indicator_pin_o == $past(bus_req.hwdata[LAMP_BURN_BIT]) &&
      lamps.check_indicator_pin_o == $past(bus_req.hwdata[LAMP_CHECK_BIT]);
  endproperty
  a_lamp_write: assert property (p_lamp_write)
    else $error("lamp levels do not follow the lamp register");

  // once latched, address and data stay put until hold drops
  property p_latch_keep;
    eprom_ctl.latch_valid |=> !eprom_ctl.latch_valid ||
      ($stable(eprom_ctl.latch_addr) && $stable(eprom_ctl.latch_data));
  endproperty
  a_latch_keep: assert property (p_latch_keep)
    else $error("latched eprom write changed before hold cleared");

endmodule : eprom_bootload_program_control

`default_nettype wire

// [user_code_source.sv]
// behavioural source of user code: the external eprom or host side
// assumes fetch is a one-cycle pulse driven just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module user_code_source
  import eprom_boot_pkg::*;
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      fetch,
  input  wire logic [15:0]               fetch_addr,
  output var  eprom_boot_pkg::eprom_wr_t cpu_wr
);
  // one byte per fetch, the address passes straight through
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cpu_wr <= '0;
    else if (fetch)
      cpu_wr <= '{valid: 1'b1, addr: fetch_addr,
                  data: fetch_addr[7:0] ^ 8'h5A};
    else
      // released lines invert on every idle edge, so a stale copy matches again every other cycle
      cpu_wr <= '{valid: 1'b0, addr: ~cpu_wr.addr, data: ~cpu_wr.data};
  end
endmodule : user_code_source
`default_nettype wire

// [tb_top.sv]
// self-checking bench: ahb-lite master tasks, strap pins, user code source
// assumes the slave answers with hreadyout and the ctrl/status/lamp map
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eprom_boot_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, fetch; // bench-driven strobes
  logic [31:0] haddr, hwdata, rd;                 // bus address, data
  logic [1:0]  htrans;                            // transfer kind
  logic [15:0] cpu_addr, fetch_addr;              // cpu and source address
  boot_pins_t  pins;                              // straps and selects
  ahb_req_t    bus_req;                           // assembled request
  ahb_resp_t   bus_resp;                          // slave answer
  eprom_wr_t   cpu_wr;                            // source writes
  eprom_ctl_t  eprom_ctl;                         // array controls
  lamp_pins_t  lamps;                             // indicator pins
  logic        boot_mode, boot_rom_select;        // mode outputs
  boot_fn_t    boot_function;                     // decoded function
  int          n_fail, tests_run;                 // verdict counters

  // the one slave's hreadyout is the bus hready
  assign bus_req = '{hsel: hsel, haddr: haddr, htrans: htrans,
                     hwrite: hwrite, hsize: 3'h2, hwdata: hwdata,
                     hready: bus_resp.hreadyout};

  eprom_bootload_program_control i_eprom_bootload_program_control (
    .hclk(hclk), .hresetn(hresetn), .bus_req(bus_req), .bus_resp(bus_resp),
    .pins(pins), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .eprom_ctl(eprom_ctl), .lamps(lamps), .boot_mode(boot_mode),
    .boot_function(boot_function), .boot_rom_select(boot_rom_select));

  user_code_source i_user_code_source (
    .hclk(hclk), .hresetn(hresetn), .fetch(fetch),
    .fetch_addr(fetch_addr), .cpu_wr(cpu_wr));

  // free-running 100 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // one single transfer; the wait on hready has no fixed length
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (bus_resp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (bus_resp.hreadyout !== 1'b1);
    r = bus_resp.hrdata;
    #1;
  endtask : bus

  task automatic do_reset(input logic boot);
    hresetn <= 1'b0;
    pins    <= '{boot, boot, 1'b0, 1'b0, 1'b0};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
  endtask : do_reset

  // ask the source for one byte and let the latch take it
  task automatic send(input logic [15:0] a);
    @(posedge hclk);
    fetch_addr <= a;
    fetch      <= 1'b1;
    @(posedge hclk);
    fetch      <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
  endtask : send

  task automatic t_user;
    do_reset(1'b0);
    check("boot_mode", boot_mode, 0);
    check("function", boot_function, FN_NONE);
    check("burn oe_n", lamps.burn_indicator_pin_oe_n, 1);
    bus(1'b1, LAMP_OFFSET, 32'h3, rd);
    check("check lamp", lamps.check_indicator_pin_o, 0);
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    check("status", rd, 32'h88);
    $display("test user_mode done");
  endtask : t_user

  task automatic t_boot_select;
    boot_fn_t exp;
    do_reset(1'b1);
    check("boot_mode", boot_mode, 1);
    check("nvm_burn_control_voltage", eprom_ctl.nvm_burn_control_voltage, 0);
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    check("status", rd, 32'h81);
    for (int i = 0; i < 8; i++)
    begin
      pins.function_select_high <= i[2];
      pins.function_select_mid  <= i[1];
      pins.function_select_low  <= i[0];
      repeat (2) @(posedge hclk);
      #1;
      exp = i[2] ? FN_SECURE : (i == 3 ? FN_NONE : boot_fn_t'(i[2:0]));
      check("function", boot_function, exp);
    end
    pins <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    $display("test boot_select done");
  endtask : t_boot_select

  task automatic t_lamps_rom;
    logic [15:0] a[4];
    a = '{16'h3EFF, 16'h3F00, 16'h3FEF, 16'h3FF0};
    bus(1'b1, LAMP_OFFSET, 32'h1, rd);
    check("burn lamp", lamps.burn_indicator_pin_o, 1);
    check("check lamp", lamps.check_indicator_pin_o, 0);
    check("check oe_n", lamps.check_indicator_pin_oe_n, 0);
    bus(1'b1, LAMP_OFFSET, 32'h2, rd);
    check("check lamp", lamps.check_indicator_pin_o, 1);
    foreach (a[i])
    begin
      cpu_addr <= a[i];
      @(posedge hclk);
      #1;
      check("rom select", boot_rom_select, i == 1 || i == 2);
    end
    $display("test lamps_rom done");
  endtask : t_lamps_rom

  task automatic t_program;
    bus(1'b1, CTRL_OFFSET, 32'h04, rd);
    check("read_en", eprom_ctl.read_en, 0);
    check("nvm_burn_control_voltage", eprom_ctl.nvm_burn_control_voltage, 0);
    send(16'h0123);
    check("latch_valid", eprom_ctl.latch_valid, 1);
    check("latch_addr", eprom_ctl.latch_addr, 16'h0123);
    check("latch_data", eprom_ctl.latch_data, 8'h79);
    send(16'h0456);
    check("latch_addr", eprom_ctl.latch_addr, 16'h0123);
    bus(1'b1, CTRL_OFFSET, 32'h05, rd);
    check("nvm_burn_control_voltage", eprom_ctl.nvm_burn_control_voltage, 1);
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    check("status", rd, 32'h71);
    bus(1'b1, CTRL_OFFSET, 32'h04, rd);
    check("nvm_burn_control_voltage", eprom_ctl.nvm_burn_control_voltage, 0);
    check("read_en", eprom_ctl.read_en, 0);
    bus(1'b1, CTRL_OFFSET, 32'h00, rd);
    check("read_en", eprom_ctl.read_en, 1);
    check("latch_valid", eprom_ctl.latch_valid, 0);
    $display("test program done");
  endtask : t_program

  task automatic t_refuse;
    bus(1'b1, CTRL_OFFSET, 32'h01, rd);
    check("nvm_burn_control_voltage", eprom_ctl.nvm_burn_control_voltage, 0);
    bus(1'b1, CTRL_OFFSET, 32'h05, rd);
    check("nvm_burn_control_voltage", eprom_ctl.nvm_burn_control_voltage, 0);
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    check("ctrl", rd, 32'h04);
    bus(1'b1, CTRL_OFFSET, 32'h00, rd);
    bus(1'b1, 8'h0C, 32'hFF, rd);
    bus(1'b0, 8'h0C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    check("hresp", bus_resp.hresp, HRESP_OKAY);
    $display("test refuse done");
  endtask : t_refuse

  // main sequence; every input has a value at time zero
  initial
  begin
    n_fail = 0;
    tests_run = 0;
    hresetn = 1'b0;
    {hsel, hwrite, fetch} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    cpu_addr = 16'h0000;
    fetch_addr = 16'h0000;
    pins = '0;
    t_user;
    t_boot_select;
    t_lamps_rom;
    t_program;
    t_refuse;
    test_done;
  end

  // watchdog: the tests need about a hundred cycles, this allows far more
  initial
  begin
    #100000;
    n_fail++;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
